// [pkg/sefaf_pkg.sv]
package sefaf_pkg;
    // Register byte offsets
    localparam logic [7:0] SEFAF_FLAGS_OFF = 8'h00;
    localparam logic [7:0] SEFAF_CTRL_OFF = 8'h04;
    localparam logic [7:0] SEFAF_FILT_OFF = 8'h08;
    localparam logic [7:0] SEFAF_CFG_OFF = 8'h0C;
    localparam logic [7:0] SEFAF_STAT_OFF = 8'h10;
    // Flag field positions in the flags register
    localparam int SEFAF_EXT1_POS = 0;
    localparam int SEFAF_EXT2_POS = 1;
    localparam int SEFAF_IDX1_POS = 2;
    localparam int SEFAF_IDX2_POS = 3;
    // Control bits
    localparam int SEFAF_RUN_POS = 0;
    // General input numbers carrying the two interrupt sources
    localparam int SEFAF_EXT1_INPUT = 11;
    localparam int SEFAF_EXT2_INPUT = 12;
    // Filter cutoff limit and reset value, in hertz
    localparam logic [15:0] SEFAF_FILT_MAX_HZ = 16'h012C;
    localparam logic [15:0] SEFAF_FILT_RST_HZ = 16'h012C;
    localparam int SEFAF_FILT_W = 16;
    localparam int SEFAF_NFLAGS = 4;
    // Program run state
    typedef enum logic [1:0] {
        SEFAF_IDLE, SEFAF_RUN
    } sefaf_prog_type;
endpackage

// [pkg/sefaf_sync_if.sv]
interface sefaf_sync_if #(parameter int N = 4);
    logic [N-1:0] raw;
    logic [N-1:0] rise;
    modport src (output raw, input rise);
    modport det (input raw, output rise);
endinterface

// [hdl/sefaf_edge_det.sv]
module sefaf_edge_det
    import sefaf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    sefaf_sync_if.det sif
);
    localparam int N = SEFAF_NFLAGS;
    logic [N-1:0] s1_r, s2_r, s3_r, rise_r;
    logic [N-1:0] s1_nxt, s2_nxt, s3_nxt, rise_nxt;

    // Two-stage sync, then edge on second and third stage
    always_comb begin
        s1_nxt = sif.raw;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        rise_nxt = s2_r & ~s3_r; // RL10
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            rise_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            rise_r <= rise_nxt;
        end
    end

    assign sif.rise = rise_r;
endmodule

// [hdl/sefaf_top.sv]
// Function
// RL1: Interrupt input going OFF to ON sets its external event flag.
// RL2: Event source 1 is general input 11, source 2 is input 12.
// RL3: Reading external flags keeps them; software writes OFF to clear.
// RL4: Encoder 1 or 2 index pulse sets its index event flag.
// RL5: Index flags survive reads; software writes OFF to clear them.
// RL6: Program end forces all external and index flags OFF.
// RL7: Filter setting is cutoff in hertz, capped at 300 Hz.
// RL8: Program-written filter holds only while running; end restores config.
// RL9: Without a program write, the stored configuration cutoff applies.
// RL10: Inputs synchronised before edge detect; set beats clear.
module sefaf_top
    import sefaf_pkg::*;
#(
    parameter int GPIN_W = 16
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [GPIN_W-1:0] gen_in,
    input wire logic [1:0] enc_index,
    output logic [3:0] event_flags,
    output logic [15:0] filter_cutoff_hz,
    output logic prog_running
);
    sefaf_sync_if #(.N(SEFAF_NFLAGS)) sif ();

    // Source selection
    assign sif.raw = {enc_index[1], enc_index[0],
                      gen_in[SEFAF_EXT2_INPUT], gen_in[SEFAF_EXT1_INPUT]}; // RL2

    sefaf_edge_det u_edge (
        .clk(clk),
        .rst(rst),
        .sif(sif)
    );

    // Program run state
    logic run_r;
    logic run_nxt;
    // Stored configuration cutoff
    logic [15:0] cfg_r;
    logic [15:0] cfg_nxt;
    // Cutoff written by the running program
    logic [15:0] prog_filt_r;
    logic [15:0] prog_filt_nxt;
    // Program has overridden the cutoff
    logic prog_set_r;
    logic prog_set_nxt;
    // Effective cutoff
    logic [15:0] cut_r;
    logic [15:0] cut_nxt;
    // Sticky event flags
    logic [3:0] flags_r;
    logic [3:0] flags_nxt;
    // Registered bus answer
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    // Bus qualifiers and per-register write strobes
    logic wr_en;
    logic rd_en;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_filt;
    logic wr_flags;
    // Program-end strobe
    logic prog_end;

    // Clamp a requested cutoff to the upper limit
    function automatic logic [15:0] clamp_hz(input logic [31:0] v);
        if (v > {16'h0000, SEFAF_FILT_MAX_HZ}) begin
            clamp_hz = SEFAF_FILT_MAX_HZ; // RL7
        end else begin
            clamp_hz = v[15:0];
        end
    endfunction

    // Access-phase qualifiers; one wait state makes each answer registered
    assign wr_en = psel & penable & pwrite & ~pready_r;
    assign rd_en = psel & penable & ~pwrite & ~pready_r;

    // Write strobes, one per writable register
    assign wr_ctrl = wr_en & (paddr == SEFAF_CTRL_OFF);
    assign wr_cfg = wr_en & (paddr == SEFAF_CFG_OFF);
    assign wr_filt = wr_en & (paddr == SEFAF_FILT_OFF);
    assign wr_flags = wr_en & (paddr == SEFAF_FLAGS_OFF);

    // Run falling; taken from the write, not run_nxt, to avoid a loop
    assign prog_end = wr_ctrl & run_r & ~pwdata[SEFAF_RUN_POS];

    // Program state and filter next values
    always_comb begin
        run_nxt = run_r;
        cfg_nxt = cfg_r;
        prog_filt_nxt = prog_filt_r;
        prog_set_nxt = prog_set_r;
        if (wr_ctrl) begin
            run_nxt = pwdata[SEFAF_RUN_POS];
        end
        // Stored value may change at any time
        if (wr_cfg) begin
            cfg_nxt = clamp_hz(pwdata); // RL7
        end
        // Program writes count only while it runs
        if (wr_filt && run_r) begin
            prog_filt_nxt = clamp_hz(pwdata); // RL7 RL8
            prog_set_nxt = 1'b1;
        end
        // Program end drops the override
        if (prog_end) begin
            prog_set_nxt = 1'b0; // RL8
        end
        // Override if set, otherwise the stored value
        if (prog_set_nxt) begin
            cut_nxt = prog_filt_nxt; // RL8
        end else begin
            cut_nxt = cfg_nxt; // RL9
        end
    end

    // Program state and filter registers
    always_ff @(posedge clk) begin
        if (rst) begin
            run_r <= 1'b0;
            cfg_r <= SEFAF_FILT_RST_HZ;
            prog_filt_r <= SEFAF_FILT_RST_HZ;
            prog_set_r <= 1'b0;
            cut_r <= SEFAF_FILT_RST_HZ;
        end else begin
            run_r <= run_nxt;
            cfg_r <= cfg_nxt;
            prog_filt_r <= prog_filt_nxt;
            prog_set_r <= prog_set_nxt;
            cut_r <= cut_nxt;
        end
    end

    // Sticky flags next value
    always_comb begin
        flags_nxt = flags_r;
        // Writing 0 to a bit clears it; 1 leaves it
        if (wr_flags) begin
            flags_nxt = flags_r & pwdata[SEFAF_NFLAGS-1:0]; // RL3 RL5
        end
        if (prog_end) begin
            flags_nxt = '0; // RL6
        end
        // Set after clear so a same-cycle event survives
        flags_nxt = flags_nxt | sif.rise; // RL1 RL4 RL10
    end

    // Sticky flag registers
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Read mux, reads leave flags untouched
    always_comb begin
        prdata_nxt = '0;
        pready_nxt = psel & penable & ~pready_r;
        pslverr_nxt = 1'b0;
        if (rd_en || wr_en) begin
            if (paddr == SEFAF_FLAGS_OFF) begin
                prdata_nxt = {28'h0000000, flags_r}; // RL3 RL5
            end else if (paddr == SEFAF_CTRL_OFF) begin
                prdata_nxt = {31'h00000000, run_r};
            end else if (paddr == SEFAF_FILT_OFF) begin
                prdata_nxt = {16'h0000, cut_r};
            end else if (paddr == SEFAF_CFG_OFF) begin
                prdata_nxt = {16'h0000, cfg_r};
            end else if (paddr == SEFAF_STAT_OFF) begin
                prdata_nxt = {30'h00000000, prog_set_r, run_r};
            end else begin
                pslverr_nxt = 1'b1;
            end
            if (wr_en) begin
                prdata_nxt = '0;
            end
        end
    end

    // Bus answer registers
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Outputs straight from their registers
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign event_flags = flags_r;
    assign filter_cutoff_hz = cut_r;
    assign prog_running = run_r;
endmodule

// [testbench/sefaf_props.sv]
module sefaf_props
    import sefaf_pkg::*;
#(parameter int GPIN_W = 16)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic [GPIN_W-1:0] gen_in,
    input wire logic [1:0] enc_index,
    input wire logic [3:0] event_flags,
    input wire logic [15:0] filter_cutoff_hz,
    input wire logic prog_running
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // One answer pulse per access
    sequence ans_s;
        pready ##1 !pready;
    endsequence
    ack_once_a: assert property (psel && penable && !pready |=> ans_s)
        else $error("no answer");
    ext_one_a: assert property
        ($rose(gen_in[11]) |-> ##[2:5] event_flags[0]) else $error("e1");
    ext_two_a: assert property
        ($rose(gen_in[12]) |-> ##[2:5] event_flags[1]) else $error("e2");
    idx_one_a: assert property
        ($rose(enc_index[0]) |-> ##[2:5] event_flags[2]) else $error("i1");
    idx_two_a: assert property
        ($rose(enc_index[1]) |-> ##[2:5] event_flags[3]) else $error("i2");
    read_keeps_a: assert property
        (psel && !pwrite |=> ($past(event_flags) & ~event_flags) == 4'h0)
        else $error("read cleared");
    end_clears_a: assert property
        ($fell(prog_running) |-> ##[0:1] event_flags == 4'h0)
        else $error("end kept");
    cut_cap_a: assert property
        (filter_cutoff_hz <= SEFAF_FILT_MAX_HZ) else $error("cap");
    cut_idle_a: assert property
        (!prog_running && !psel |=> $stable(filter_cutoff_hz))
        else $error("idle cut");
endmodule
bind sefaf_top sefaf_props #(.GPIN_W(GPIN_W)) chk (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .gen_in(gen_in), .enc_index(enc_index), .event_flags(event_flags),
    .filter_cutoff_hz(filter_cutoff_hz), .prog_running(prog_running));

// [testbench/sefaf_pins.sv]
module sefaf_pins (
    input wire logic clk,
    output logic [15:0] gen_in = 16'h0000,
    output logic [1:0] enc_index = 2'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // One line high two cycles, low two; general inputs other than 11 and 12 carry noise
    task automatic pulse(input int n, input logic [15:0] noise);
        logic [17:0] m;
        m = 18'h00001 << n;
        @(posedge clk);
        gen_in <= (noise & 16'hE7FF) | m[15:0];
        enc_index <= m[17:16];
        repeat (2) @(posedge clk);
        gen_in <= noise & 16'hE7FF;
        enc_index <= 2'h0;
        repeat (2) @(posedge clk);
    endtask
endmodule

// [testbench/sticky_event_flags_and_filter_tb.sv]
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
    failures++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
module sticky_event_flags_and_filter_tb;
    import sefaf_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, err, prog_running;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] gen_in, cut, cfg, lf = 16'h35B5;
    logic [1:0] enc_index;
    logic [3:0] event_flags, exp_f;
    int failures = 0, checks_done = 0;
    sefaf_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gen_in(gen_in),
        .enc_index(enc_index), .event_flags(event_flags),
        .filter_cutoff_hz(cut), .prog_running(prog_running));
    sefaf_pins pins (.clk(clk), .gen_in(gen_in), .enc_index(enc_index));
    initial begin
        forever #50 clk = ~clk;
    end
    // Next value of the stimulus shift register
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [15:0] clamp(input logic [15:0] v);
        return (v > SEFAF_FILT_MAX_HZ) ? SEFAF_FILT_MAX_HZ : v;
    endfunction
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            $display("mismatch pready exp 1 got %0h", pready);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #200000;
        failures++;
        results();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 8'h14, 0);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, SEFAF_FILT_OFF, 100);
        `CHK("idle filt", 16'h012C, cut)
        for (int i = 0; i < 3; i++) begin
            lf = lfsr(lf);
            cfg = (i == 0) ? 16'h012D : {7'h00, lf[8:0]};
            apb(1'b1, SEFAF_CFG_OFF, cfg);
            apb(1'b1, SEFAF_CTRL_OFF, 1);
            `CHK("running", 1'b1, prog_running)
            `CHK("cfg cut", clamp(cfg), cut)
            apb(1'b1, SEFAF_FILT_OFF, lf[15:7]);
            apb(1'b0, SEFAF_FILT_OFF, 0);
            `CHK("prog cut", clamp({7'h00, lf[15:7]}), rd[15:0])
            exp_f = 4'h0;
            for (int b = 0; b < 4; b++) begin
                pins.pulse(b < 2 ? 11 + b : 14 + b, lf);
                exp_f[b] = 1'b1;
                apb(1'b0, SEFAF_FLAGS_OFF, 0);
                `CHK("flags", exp_f, rd[3:0])
            end
            apb(1'b1, SEFAF_FLAGS_OFF, 32'h0000000A);
            `CHK("clear", 4'hA, event_flags)
            apb(1'b1, SEFAF_CTRL_OFF, 0);
            apb(1'b0, SEFAF_STAT_OFF, 0);
            `CHK("stat", 2'h0, rd[1:0])
            `CHK("end cut", clamp(cfg), cut)
            `CHK("end flags", 4'h0, event_flags)
            $display("pass %0d done", i);
        end
        results();
    end
endmodule
